/* src/fps_flash_program_erase_sequencer.sv */
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module fps_flash_program_erase_sequencer #(
    parameter int ROW_TICKS = fps_pkg::ROW_CYCLES,    // Row write length
    parameter int OTHER_TICKS = fps_pkg::OTHER_CYCLES, // Other operations length
    parameter int ADDR_W = 24                         // Target address width
) (
    input wire logic aclk,                   // System clock, 125 MHz
    input wire logic aresetn,                // Synchronous reset, low
    input wire logic osc_tick,               // Internal oscillator tick enable
    input wire logic [ADDR_W-1:0] target_addr, // Table pointer address
    input wire logic [3:0] s_axi_awaddr,     // Write address
    input wire logic s_axi_awvalid,          // Write address valid
    output logic s_axi_awready,              // Write address ready
    input wire logic [31:0] s_axi_wdata,     // Write data
    input wire logic [3:0] s_axi_wstrb,      // Write strobes
    input wire logic s_axi_wvalid,           // Write data valid
    output logic s_axi_wready,               // Write data ready
    output logic [1:0] s_axi_bresp,          // Write response
    output logic s_axi_bvalid,               // Write response valid
    input wire logic s_axi_bready,           // Write response ready
    input wire logic [3:0] s_axi_araddr,     // Read address
    input wire logic s_axi_arvalid,          // Read address valid
    output logic s_axi_arready,              // Read address ready
    output logic [31:0] s_axi_rdata,         // Read data
    output logic [1:0] s_axi_rresp,          // Read response
    output logic s_axi_rvalid,               // Read data valid
    input wire logic s_axi_rready,           // Read data ready
    output logic cpu_stall,                  // Hold processor execution
    output fps_pkg::fps_op_s array_op,       // Operation to the array
    output logic [ADDR_W-1:0] array_addr,    // Aligned array address
    output logic irq                         // Level interrupt
);
    // Write channel state
    logic aw_held_r, aw_held_nxt;
    logic [3:0] aw_addr_r, aw_addr_nxt;
    logic w_held_r, w_held_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    // Read channel state
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    // Block state
    logic start_r, start_nxt;
    logic permit_r, permit_nxt;
    logic fault_r, fault_nxt;
    logic erase_r, erase_nxt;
    logic [3:0] code_r, code_nxt;
    logic [1:0] unlock_r, unlock_nxt;
    logic [15:0] ticks_r, ticks_nxt;
    fps_pkg::fps_op_e op_r, op_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [1:0] sts_r, sts_nxt;
    logic [1:0] mask_r, mask_nxt;
    logic wr_fire;
    logic [15:0] ctrl_view;

    // operation decode
    // Erase bit picks the table, unlisted codes decode to none
    function automatic fps_pkg::fps_op_e decode_op(input logic erase, input logic [3:0] code);
        fps_pkg::fps_op_e res;
        res = fps_pkg::FPS_NONE;
        if (erase) begin
            if (code == fps_pkg::OP_BULK) res = fps_pkg::FPS_BULK;
            else if (code == fps_pkg::OP_SEGMENT) res = fps_pkg::FPS_SEGMENT;
            else if (code == fps_pkg::OP_PAGE) res = fps_pkg::FPS_PAGE;
            else if (code == fps_pkg::OP_CONFIG) res = fps_pkg::FPS_CONFIG;
        end else begin
            if (code == fps_pkg::OP_WORD) res = fps_pkg::FPS_WORD;
            else if (code == fps_pkg::OP_ROW) res = fps_pkg::FPS_ROW;
        end
        return res;
    endfunction

    function automatic logic [ADDR_W-1:0] align_addr(input logic [ADDR_W-1:0] a,
                                                     input int unsigned unit);
        return a - ADDR_W'(a % unit);
    endfunction

    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign ctrl_view = {start_r, permit_r, fault_r, 6'h00, erase_r, 2'b00, code_r};

    // Bus, control and sequencer next state
    always_comb begin
        fps_pkg::fps_op_e dec;
        logic [15:0] wd;
        wd = w_data_r[15:0];
        // Decode with the fields this very write brings, lane 0 absent keeps the old ones
        dec = decode_op(w_strb_r[0] ? wd[fps_pkg::ERASE_BIT] : erase_r,
                        w_strb_r[0] ? wd[fps_pkg::CODE_LSB +: 4] : code_r);
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt = w_held_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        start_nxt = start_r;
        permit_nxt = permit_r;
        fault_nxt = fault_r;
        erase_nxt = erase_r;
        code_nxt = code_r;
        unlock_nxt = unlock_r;
        ticks_nxt = ticks_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        sts_nxt = sts_r;
        mask_nxt = mask_r;
        // Address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
        // Status clear first so hardware sets below win
        if (wr_fire && aw_addr_r == fps_pkg::ADDR_IRQ_STATUS && w_strb_r[0])
            sts_nxt = sts_r & ~w_data_r[1:0];
        if (start_r && osc_tick) begin
            if (ticks_r <= 16'd1) begin
                start_nxt = 1'b0;
                op_nxt = fps_pkg::FPS_NONE;
                sts_nxt[fps_pkg::IRQ_DONE] = 1'b1;
            end else begin
                ticks_nxt = ticks_r - 16'd1;
            end
        end
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = fps_pkg::RESP_OKAY;
            // any other write breaks the unlock
            unlock_nxt = 2'd0;
            if (aw_addr_r == fps_pkg::ADDR_KEY) begin
                if (w_strb_r[0] && wd[7:0] == fps_pkg::KEY_FIRST) unlock_nxt = 2'd1;
                else if (w_strb_r[0] && unlock_r == 2'd1 && wd[7:0] == fps_pkg::KEY_SECOND)
                    unlock_nxt = 2'd2;
            end else if (aw_addr_r == fps_pkg::ADDR_CONTROL) begin
                // Fields frozen while an operation runs
                if (!start_r && w_strb_r[0]) begin
                    erase_nxt = wd[fps_pkg::ERASE_BIT];
                    code_nxt = wd[fps_pkg::CODE_LSB +: 4];
                end
                if (!start_r && w_strb_r[1]) begin
                    permit_nxt = wd[fps_pkg::PERMIT_BIT];
                    fault_nxt = wd[fps_pkg::FAULT_BIT];
                    if (wd[fps_pkg::START_BIT]) begin
                        if (unlock_r != 2'd2 || !wd[fps_pkg::PERMIT_BIT]) begin
                            fault_nxt = 1'b1;
                            sts_nxt[fps_pkg::IRQ_FAULT] = 1'b1;
                        end else if (dec == fps_pkg::FPS_NONE) begin
                            fault_nxt = 1'b0;
                        end else begin
                            start_nxt = 1'b1;
                            fault_nxt = 1'b0;
                            op_nxt = dec;
                            ticks_nxt = (dec == fps_pkg::FPS_ROW) ? 16'(ROW_TICKS) :
                                        16'(OTHER_TICKS);
                            addr_nxt = (dec == fps_pkg::FPS_ROW) ?
                                       align_addr(target_addr, fps_pkg::ROW_BYTES) :
                                       align_addr(target_addr, fps_pkg::PAGE_BYTES);
                        end
                    end
                end
            end else if (aw_addr_r == fps_pkg::ADDR_IRQ_MASK) begin
                if (w_strb_r[0]) mask_nxt = w_data_r[1:0];
            end else if (aw_addr_r != fps_pkg::ADDR_IRQ_STATUS) begin
                bresp_nxt = fps_pkg::RESP_SLVERR;
            end
        end
        // Read side, answer one cycle after address
        if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = fps_pkg::RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            if (s_axi_araddr == fps_pkg::ADDR_CONTROL) rdata_nxt = {16'h0000, ctrl_view};
            else if (s_axi_araddr == fps_pkg::ADDR_KEY) rdata_nxt = 32'h0000_0000;
            else if (s_axi_araddr == fps_pkg::ADDR_IRQ_STATUS) rdata_nxt = {30'h0, sts_r};
            else if (s_axi_araddr == fps_pkg::ADDR_IRQ_MASK) rdata_nxt = {30'h0, mask_r};
            else rresp_nxt = fps_pkg::RESP_SLVERR;
        end
    end

    // Register everything
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'b00;
            {start_r, permit_r, fault_r} <= fps_pkg::CONTROL_RESET[fps_pkg::START_BIT -: 3];
            erase_r <= fps_pkg::CONTROL_RESET[fps_pkg::ERASE_BIT];
            code_r <= fps_pkg::CONTROL_RESET[fps_pkg::CODE_LSB +: 4];
            unlock_r <= 2'd0;
            ticks_r <= 16'h0000;
            op_r <= fps_pkg::FPS_NONE;
            addr_r <= '0;
            sts_r <= 2'b00;
            mask_r <= 2'b00;
        end else begin
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r <= w_held_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            start_r <= start_nxt;
            permit_r <= permit_nxt;
            fault_r <= fault_nxt;
            erase_r <= erase_nxt;
            code_r <= code_nxt;
            unlock_r <= unlock_nxt;
            ticks_r <= ticks_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            sts_r <= sts_nxt;
            mask_r <= mask_nxt;
        end
    end

    // Handshakes and outputs
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign cpu_stall = start_r;
    assign array_op = '{op: op_r, busy: start_r};
    assign array_addr = addr_r;
    assign irq = |(sts_r & mask_r);

    AST_STALL: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_stall == start_r && (start_r == (op_r != fps_pkg::FPS_NONE)))
        else $error("stall and operation disagree");
    AST_FINISH: assert property (@(posedge aclk) disable iff (!aresetn)
        start_r && osc_tick && ticks_r == 16'd1 |=> !start_r && sts_r[fps_pkg::IRQ_DONE])
        else $error("operation did not finish");
    // start cannot be cleared by software
    AST_NOCLR: assert property (@(posedge aclk) disable iff (!aresetn)
        start_r && !(osc_tick && ticks_r <= 16'd1) |=> start_r)
        else $error("start dropped early");
    AST_KEYRD: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == fps_pkg::ADDR_KEY
        |=> s_axi_rdata == 32'h0000_0000)
        else $error("key readable");
    AST_PERMIT: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(start_r) |-> permit_r)
        else $error("launch without permit");
    AST_UNLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(start_r) |-> $past(unlock_r) == 2'd2)
        else $error("launch without unlock");
    AST_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && aw_addr_r == fps_pkg::ADDR_CONTROL && !start_r && w_strb_r[1]
        && w_data_r[fps_pkg::START_BIT] && unlock_r != 2'd2 |=> fault_r)
        else $error("fault not raised");
    AST_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_view[12:7] == 6'h00 && ctrl_view[5:4] == 2'b00)
        else $error("reserved bits set");
    COV_LAUNCH: cover property (@(posedge aclk) disable iff (!aresetn) $rose(start_r));
    COV_DONE: cover property (@(posedge aclk) disable iff (!aresetn) $fell(start_r));
    COV_FAULT: cover property (@(posedge aclk) disable iff (!aresetn) $rose(fault_r));
endmodule // fps_flash_program_erase_sequencer

/* src/fps_pkg.sv */
package fps_pkg;
    // Register byte addresses on the AXI4-Lite bus
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_KEY = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
    // Control register field positions
    localparam int START_BIT = 15;
    localparam int PERMIT_BIT = 14;
    localparam int FAULT_BIT = 13;
    localparam int ERASE_BIT = 6;
    localparam int CODE_LSB = 0;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    // Unlock key values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // Operation codes
    localparam logic [3:0] OP_BULK = 4'hF;
    localparam logic [3:0] OP_SEGMENT = 4'hD;
    localparam logic [3:0] OP_WORD = 4'h3;
    localparam logic [3:0] OP_PAGE = 4'h2;
    localparam logic [3:0] OP_ROW = 4'h1;
    localparam logic [3:0] OP_CONFIG = 4'h0;
    // Geometry
    localparam int PAGE_BYTES = 1536;
    localparam int ROW_BYTES = 192;
    // Durations in oscillator cycles
    localparam int ROW_CYCLES = 11064;
    localparam int OTHER_CYCLES = 11064;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAULT = 1;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        FPS_NONE, FPS_BULK, FPS_SEGMENT, FPS_PAGE, FPS_CONFIG, FPS_WORD, FPS_ROW
    } fps_op_e;

    // Operation request to the array
    typedef struct packed {
        fps_op_e op;
        logic busy;
    } fps_op_s;
endpackage

/* testbench/fps_flash_program_erase_sequencer_test.sv */
`timescale 1ns/10ps
module fps_flash_program_erase_sequencer_test;
    localparam int ROW_T = 8;
    localparam int OTH_T = 5;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic osc_tick = 1'b0;
    logic tick_on = 1'b0;
    logic [23:0] target_addr = 24'h00_1a2b;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'b0011;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic cpu_stall;
    fps_pkg::fps_op_s array_op;
    logic [23:0] array_addr;
    logic irq;
    int miscompares = 0;
    int n_compared = 0;
    int tick_cnt = 0;
    int div = 0;
    logic [31:0] rd_data;
    logic [1:0] rsp;
    logic [15:0] op_c[6] = '{16'hc001, 16'hc003, 16'hc04f, 16'hc04d, 16'hc042, 16'hc040};
    fps_pkg::fps_op_e op_e[6] = '{fps_pkg::FPS_ROW, fps_pkg::FPS_WORD, fps_pkg::FPS_BULK,
        fps_pkg::FPS_SEGMENT, fps_pkg::FPS_PAGE, fps_pkg::FPS_CONFIG};
    logic [15:0] nop_c[7] = '{16'hc043, 16'hc041, 16'hc00f, 16'hc00d, 16'hc002, 16'hc047, 16'hc005};

    fps_flash_program_erase_sequencer #(.ROW_TICKS(ROW_T), .OTHER_TICKS(OTH_T), .ADDR_W(24))
    u_fps_flash_program_erase_sequencer (.aclk(aclk), .aresetn(aresetn), .osc_tick(osc_tick),
        .target_addr(target_addr), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .cpu_stall(cpu_stall), .array_op(array_op), .array_addr(array_addr), .irq(irq));

    // 125 MHz system clock
    initial begin
        forever #4 aclk = ~aclk;
    end

    // Oscillator ticks every third cycle; gated so the test decides when time passes
    always @(posedge aclk) begin
        div <= (div == 2) ? 0 : div + 1;
        osc_tick <= tick_on && (div == 2);
    end

    // Count ticks the design sees while stalled
    always @(negedge aclk) begin
        if (cpu_stall === 1'b1 && osc_tick === 1'b1) begin
            tick_cnt++;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t response %b expected %b", $time, got, exp);
        end
    endtask

    // Handshakes judged at the falling edge, so the rising edge sees the same values
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        int n;
        logic ha;
        logic hw;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ha = s_axi_awvalid & s_axi_awready;
            hw = s_axi_wvalid & s_axi_wready;
            done = s_axi_bvalid & s_axi_bready;
            rsp = s_axi_bresp;
            n++;
            if (n > 100) begin
                miscompares++;
                $display("[FAIL] %0t write handshake timed out", $time);
                done = 1'b1;
            end
            @(posedge aclk);
            if (ha === 1'b1) s_axi_awvalid <= 1'b0;
            if (hw === 1'b1) s_axi_wvalid <= 1'b0;
            if (done === 1'b1) s_axi_bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [3:0] a);
        int n;
        logic ha;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ha = s_axi_arvalid & s_axi_arready;
            done = s_axi_rvalid & s_axi_rready;
            rd_data = s_axi_rdata;
            rsp = s_axi_rresp;
            n++;
            if (n > 100) begin
                miscompares++;
                $display("[FAIL] %0t read handshake timed out", $time);
                done = 1'b1;
            end
            @(posedge aclk);
            if (ha === 1'b1) s_axi_arvalid <= 1'b0;
            if (done === 1'b1) s_axi_rready <= 1'b0;
        end
    endtask

    task automatic unlock();
        wr(fps_pkg::ADDR_KEY, 16'h0055);
        wr(fps_pkg::ADDR_KEY, 16'h00aa);
    endtask

    // Refused start: flag, status and interrupt, then clean up
    task automatic want_fault(input logic exp_irq);
        repeat (4) @(negedge aclk);
        chk(32'(cpu_stall), 32'h0000_0000);
        rd(fps_pkg::ADDR_CONTROL);
        chk(rd_data & 32'h0000_a000, 32'h0000_2000);
        rd(fps_pkg::ADDR_IRQ_STATUS);
        chk(rd_data, 32'h0000_0002);
        chk(32'(irq), 32'(exp_irq));
        wr(fps_pkg::ADDR_IRQ_STATUS, 16'h0002);
        wr(fps_pkg::ADDR_CONTROL, 16'h0000);
        rd(fps_pkg::ADDR_CONTROL);
        chk(rd_data, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
    endtask

    // One full operation; time only passes while ticks are let through
    task automatic run_op(input logic [15:0] c, input fps_pkg::fps_op_e op, input int t,
                          input int al);
        int n;
        n = 0;
        tick_cnt = 0;
        unlock();
        wr(fps_pkg::ADDR_CONTROL, c);
        do begin
            @(negedge aclk);
            n++;
        end while (cpu_stall !== 1'b1 && n < 10);
        chk(32'(cpu_stall), 32'h0000_0001);
        chk(32'(array_op), 32'({op, 1'b1}));
        chk(32'(array_addr), 32'(target_addr - target_addr % al));
        repeat (6) @(negedge aclk);
        chk(32'(cpu_stall), 32'h0000_0001);
        wr(fps_pkg::ADDR_CONTROL, 16'h0000);
        rd(fps_pkg::ADDR_CONTROL);
        chk(rd_data, 32'(c));
        // slots after start, then wait out the time
        tick_on <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (cpu_stall === 1'b1 && n < 200);
        tick_on <= 1'b0;
        chk(32'(tick_cnt), 32'(t));
        rd(fps_pkg::ADDR_CONTROL);
        chk(rd_data, 32'(c & 16'h7fff));
        rd(fps_pkg::ADDR_IRQ_STATUS);
        chk(rd_data, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        wr(fps_pkg::ADDR_IRQ_STATUS, 16'h0001);
        repeat (2) @(negedge aclk);
        chk(32'(irq), 32'h0000_0000);
    endtask

    task automatic wrap_up();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(4'(i * 4));
            chk(rd_data, 32'h0000_0000);
            chk_resp(rsp, fps_pkg::RESP_OKAY);
        end
        rd(4'h1);
        chk_resp(rsp, fps_pkg::RESP_SLVERR);
        chk(rd_data, 32'h0000_0000);
        wr(4'h1, 16'h1234);
        chk_resp(rsp, fps_pkg::RESP_SLVERR);
        wr(fps_pkg::ADDR_CONTROL, 16'h7fff);
        rd(fps_pkg::ADDR_CONTROL);
        chk(rd_data, 32'h0000_604f);
        // Lane 0 only: low byte lands, start in the upper byte must be ignored
        s_axi_wstrb <= 4'b0001;
        wr(fps_pkg::ADDR_CONTROL, 16'hffb0);
        s_axi_wstrb <= 4'b0011;
        rd(fps_pkg::ADDR_CONTROL);
        chk(rd_data, 32'h0000_6000);
        chk(32'(cpu_stall), 32'h0000_0000);
        wr(fps_pkg::ADDR_CONTROL, 16'h0000);
        wr(fps_pkg::ADDR_KEY, 16'hff55);
        rd(fps_pkg::ADDR_KEY);
        chk(rd_data, 32'h0000_0000);
        wr(fps_pkg::ADDR_IRQ_MASK, 16'h0003);
        rd(fps_pkg::ADDR_IRQ_MASK);
        chk(rd_data, 32'h0000_0003);
        wr(fps_pkg::ADDR_CONTROL, 16'hc001);
        want_fault(1'b1);
        unlock();
        wr(fps_pkg::ADDR_CONTROL, 16'h8001);
        want_fault(1'b1);
        wr(fps_pkg::ADDR_KEY, 16'h0055);
        wr(fps_pkg::ADDR_IRQ_MASK, 16'h0001);
        wr(fps_pkg::ADDR_KEY, 16'h00aa);
        wr(fps_pkg::ADDR_CONTROL, 16'hc001);
        want_fault(1'b0);
        wr(fps_pkg::ADDR_IRQ_MASK, 16'h0003);
        wr(fps_pkg::ADDR_KEY, 16'h00aa);
        wr(fps_pkg::ADDR_KEY, 16'h0055);
        wr(fps_pkg::ADDR_CONTROL, 16'hc001);
        want_fault(1'b1);
        for (int i = 0; i < 6; i++) begin
            target_addr <= target_addr + 24'(i) * 24'h00_0301;
            run_op(op_c[i], op_e[i], (i == 0) ? ROW_T : OTH_T, (i == 0) ? 192 : 1536);
        end
        // Page erase, then restore one row of it
        run_op(16'hc042, fps_pkg::FPS_PAGE, OTH_T, 1536);
        run_op(16'hc001, fps_pkg::FPS_ROW, ROW_T, 192);
        for (int i = 0; i < 7; i++) begin
            wr(fps_pkg::ADDR_CONTROL, 16'h2000);
            unlock();
            wr(fps_pkg::ADDR_CONTROL, nop_c[i]);
            repeat (4) @(negedge aclk);
            chk(32'(cpu_stall), 32'h0000_0000);
            rd(fps_pkg::ADDR_CONTROL);
            chk(rd_data, 32'(nop_c[i] & 16'h5fff));
        end
        wrap_up();
    end

    // Watchdog well beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule // fps_flash_program_erase_sequencer_test
